// ---- dv/field_switch_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module field_switch_model
(
  input  wire logic       mclk,
  input  wire logic [3:0] level,
  input  wire logic [3:0] bounce,
  output wire logic [3:0] term_raw
);
  logic [2:0] cnt_r = 3'h0;
  always_ff @(posedge mclk)
  begin
    cnt_r <= cnt_r + 3'h1;
  end
  // chattering contacts flip every 4 cycles, far below any non-zero reaction time (one tick is 40 cycles)
  assign term_raw = level ^ (bounce & {4{cnt_r[2]}});
endmodule
`default_nettype wire

// ---- dv/programmable_control_terminal_mapper_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module programmable_control_terminal_mapper_tb;
  import ctl_term_pkg::*;
  logic           mclk = 1'b0;
  logic           nrst = 1'b0;
  logic [7:0]     awaddr = 8'h00;
  logic [7:0]     araddr = 8'h00;
  logic [31:0]    wdata = 32'h0;
  logic           awvalid = 1'b0;
  logic           wvalid = 1'b0;
  logic           bready = 1'b0;
  logic           arvalid = 1'b0;
  logic           rready = 1'b0;
  logic           awready, wready, bvalid, arready, rvalid, irq, relay, e;
  logic [1:0]     bresp, rresp, oc;
  logic [31:0]    rdata, rd;
  logic [3:0]     lvl = 4'h0;
  logic [3:0]     bnc = 4'h0;
  logic [3:0]     term_raw;
  logic [14:0]    oh;
  status_src_type src = '0;
  drive_func_type drv;
  int             n_errors = 0;
  int             checks_done = 0;
  int             m, v, c, iv;
  logic [1:0]     pset_exp [4] = '{PSET_4, PSET_3, PSET_2, PSET_1};
  logic [2:0]     ev_exp [4] = '{3'b010, 3'b101, 3'b110, 3'b100};

  always #12.5 mclk = ~mclk;

  ctl_term_mapper u_dut (
    .mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .term_raw(term_raw),
    .status_src(src), .drive(drv), .oc_drive(oc), .relay_drive(relay),
    .irq(irq));

  field_switch_model u_sw (
    .mclk(mclk), .level(lvl), .bounce(bnc), .term_raw(term_raw));

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic close_out();
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic hang();
    n_errors++;
    $display("[ERR] bus answer exp 1 seen 0");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    if (n == 50)
      hang();
    chk("bresp", bresp, er);
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd_(input logic [7:0] a, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge mclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    if (n == 50)
      hang();
    rd = rdata;
    chk("rresp", rresp, er);
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic settle();
    repeat (8) @(posedge mclk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    chk("pset_rst", drv.param_set, PSET_4);
    rd_(FUNC_MAP_OFF, RESP_OKAY);
    chk("map_rst", rd, FUNC_MAP_RST);
    rd_(EVAL_CFG_OFF, RESP_OKAY);
    chk("eval_rst", rd, EVAL_CFG_RST);
    rd_(8'h20, RESP_SLVERR);
    wr(STATUS_OFF, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(REACT_OFF, 32'h0, RESP_OKAY);
    lvl <= 4'h4;
    settle();
    chk("rev", drv.reverse_run_request, 1'b1);
    lvl <= 4'hF;
    settle();
    chk("fwd_wins", {drv.forward_run_request, drv.reverse_run_request},
        2'h2);
    chk("hold", drv.hold_min_freq, 1'b1);
    rd_(IRQ_STAT_OFF, RESP_OKAY);
    chk("irq_stat", rd, 32'h30);
    wr(FUNC_MAP_OFF, 32'h0010_4201, RESP_OKAY);
    for (v = 0; v < 4; v++)
    begin
      lvl <= {1'b0, v[1:0], 1'b1};
      settle();
      chk("pset", drv.param_set, pset_exp[v]);
      chk("multi", {drv.forward_run_request, drv.fixed_freq},
          2'h3);
    end
    for (m = 0; m < 6; m++)
    begin
      wr(LINK_CFG_OFF, 32'(m), RESP_OKAY);
      for (v = 0; v < 4; v++)
      begin
        lvl <= {2'b00, v[1:0]};
        settle();
        case (m)
          0: e = v[0];
          1: e = !v[0];
          2: e = v[0] | v[1];
          3: e = !v[0] | !v[1];
          4: e = v[0] & v[1];
          default: e = !v[0] & !v[1];
        endcase
        chk("link", drv.forward_run_request, e);
      end
    end
    wr(LINK_CFG_OFF, 32'h0, RESP_OKAY);
    wr(FUNC_MAP_OFF, 32'h0200_0001, RESP_OKAY);
    for (m = 0; m < 4; m++)
    begin
      wr(EVAL_CFG_OFF, 32'(m), RESP_OKAY);
      lvl <= 4'h2;
      settle();
      for (v = 0; v < 3; v++)
      begin
        lvl <= {3'b000, v == 1};
        settle();
        chk("eval", drv.forward_run_request, ev_exp[m][v]);
      end
    end
    lvl <= 4'h2;
    settle();
    chk("clear", drv.forward_run_request, 1'b0);
    chk("clear_out", drv.latch_clear, 1'b1);
    wr(IRQ_STAT_OFF, 32'h3F, RESP_OKAY);
    lvl <= 4'h1;
    settle();
    lvl <= 4'h0;
    settle();
    chk("irq_masked", irq, 1'b0);
    wr(IRQ_MASK_OFF, 32'h1, RESP_OKAY);
    chk("irq_on", irq, 1'b1);
    wr(IRQ_STAT_OFF, 32'h1, RESP_OKAY);
    chk("irq_off", irq, 1'b0);
    wr(EVAL_CFG_OFF, 32'h0, RESP_OKAY);
    wr(REACT_OFF, 32'h1, RESP_OKAY);
    lvl <= 4'h1;
    bnc <= 4'h1;
    repeat (200) @(posedge mclk);
    chk("bounce", drv.forward_run_request, 1'b0);
    bnc <= 4'h0;
    repeat (100) @(posedge mclk);
    chk("steady", drv.forward_run_request, 1'b1);
    lvl <= 4'h0;
    repeat (20) @(posedge mclk);
    chk("short", drv.forward_run_request, 1'b1);
    for (c = 0; c < 16; c++)
    begin
      for (iv = 0; iv < 2; iv++)
      begin
        wr(OUT_CFG_OFF, {16'h0, 3'b0, iv[0], c[3:0], 3'b0, iv[0], c[3:0]},
           RESP_OKAY);
        for (v = 0; v < 2; v++)
        begin
          oh = (c == 0) ? 15'h0 : 15'h1 << (c - 1);
          src <= status_src_type'(v[0] ? oh : ~oh);
          repeat (3) @(posedge mclk);
          e = (c != 0) && v[0];
          chk("oc0", oc[0], e ^ iv[0]);
          e = e && (c != 14);
          chk("oc1", oc[1], e ^ iv[0]);
          chk("relay", relay, e ^ iv[0]);
        end
      end
    end
    close_out();
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    $display("[ERR] run exp end seen timeout");
    close_out();
  end
endmodule
`default_nettype wire

// ---- hw/ctl_term_mapper.sv ----
// Behaviour
// RULE_01 - four inputs each assignable to the seven converter functions
// RULE_02 - one terminal may drive several functions at once
// RULE_03 - each input selectable as high active or low active
// RULE_04 - two terminals may be combined by OR, plain or inverted
// RULE_05 - two terminals may be combined by AND, plain or inverted
// RULE_06 - evaluation: level high, level low, rising edge or falling edge
// RULE_07 - evaluation setting held apart from function assignment
// RULE_08 - reaction time rejects noise and contact bounce
// RULE_09 - each of two outputs takes one status or fault source
// RULE_10 - frequency source only allowed on the first output
// RULE_11 - relay switches with the designated second output
// RULE_12 - each output has a polarity inversion
// RULE_13 - overtemperature warning selectable as output source
// RULE_14 - latch clear resets all input latches
// RULE_15 - two select bits choose parameter set at once
// RULE_16 - forward run wins when both run requests are active
// RULE_17 - change accepted only after stable for whole reaction time
// RULE_18 - edge input sets a latch held until latch clear
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ctl_term_mapper
  import ctl_term_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [NUM_TERM-1:0]   term_raw,
  input  wire ctl_term_pkg::status_src_type status_src,
  output var ctl_term_pkg::drive_func_type  drive,
  output logic [NUM_OUT-1:0]         oc_drive,
  output logic                       relay_drive,
  output logic                       irq
);
  import ctl_term_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] byte_mask(input logic [3:0] strb);
    byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic link_val(input logic [2:0] mode,
                                    input logic a, input logic b);
    case (mode)
      LINK_DIRECT:  link_val = a;
      LINK_INV:     link_val = ~a;
      LINK_OR:      link_val = a | b;
      LINK_OR_INV:  link_val = ~a | ~b;
      LINK_AND:     link_val = a & b;
      LINK_AND_INV: link_val = ~a & ~b;
      default:      link_val = a;
    endcase
  endfunction

  function automatic logic [1:0] pset_code(input logic b0, input logic b1);
    case ({b1, b0})
      2'h3:    pset_code = PSET_1;
      2'h2:    pset_code = PSET_2;
      2'h1:    pset_code = PSET_3;
      default: pset_code = PSET_4;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0]         link_cfg_r;
  logic [31:0]         eval_cfg_r;
  logic [31:0]         func_map_r;
  logic [REACT_W-1:0]  react_r;
  logic [31:0]         out_cfg_r;
  logic [IRQ_W-1:0]    irq_stat_r;
  logic [IRQ_W-1:0]    irq_mask_r;
  logic                aw_hold_r;
  logic                w_hold_r;
  logic [ADDR_W-1:0]   aw_addr_r;
  logic [31:0]         w_data_r;
  logic [3:0]          w_strb_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                rvalid_r;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;
  logic [31:0]         rdata_nxt;
  logic                rhit_nxt;
  logic                wr_fire;
  logic                whit;
  logic [31:0]         wmask;
  logic [31:0]         bmask;

  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign wr_fire       = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wmask         = s_axi_wdata_mask();
  assign bmask         = byte_mask(w_strb_r);
  assign whit          = (aw_addr_r <= IRQ_MASK_OFF) &&
                         (aw_addr_r[1:0] == 2'h0) &&
                         (aw_addr_r != STATUS_OFF);

  function automatic logic [31:0] s_axi_wdata_mask();
    s_axi_wdata_mask = w_data_r & byte_mask(w_strb_r);
  endfunction

  // write address and data are taken in either order, answered together
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= whit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // function map and evaluation live in separate words
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      link_cfg_r <= LINK_CFG_RST;
      eval_cfg_r <= EVAL_CFG_RST; // RULE_07
      func_map_r <= FUNC_MAP_RST;
      react_r    <= REACT_RST;
      out_cfg_r  <= OUT_CFG_RST;
      irq_mask_r <= '0;
    end
    else if (wr_fire)
    begin
      case (aw_addr_r)
        LINK_CFG_OFF: link_cfg_r <= (link_cfg_r & ~bmask) | wmask;
        EVAL_CFG_OFF: eval_cfg_r <= (eval_cfg_r & ~bmask) | wmask;
        FUNC_MAP_OFF: func_map_r <= (func_map_r & ~bmask) | wmask;
        REACT_OFF:    react_r    <= (react_r & ~bmask[REACT_W-1:0]) |
                                    wmask[REACT_W-1:0];
        OUT_CFG_OFF:  out_cfg_r  <= (out_cfg_r & ~bmask) | wmask;
        IRQ_MASK_OFF: irq_mask_r <= (irq_mask_r & ~bmask[IRQ_W-1:0]) |
                                    wmask[IRQ_W-1:0];
        default:      ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // input path
  // ----------------------------------------------------------------
  logic [NUM_TERM-1:0] sync1_r;
  logic [NUM_TERM-1:0] sync2_r;
  logic [NUM_TERM-1:0] filt;
  logic [NUM_TERM-1:0] comb_r;
  logic [NUM_TERM-1:0] latch;
  logic [NUM_TERM-1:0] latch_set;
  logic [NUM_TERM-1:0] term_act;
  logic [NUM_FUNC-1:0] func;
  logic [TICK_W-1:0]   tick_cnt_r;
  logic                tick;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= term_raw;
      sync2_r <= sync1_r;
    end
  end

  // reaction time counts in microsecond ticks
  assign tick = (tick_cnt_r == TICK_W'(TICK_CYC - 1));
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      tick_cnt_r <= '0;
    else if (tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + TICK_W'(1);
  end

  genvar g;
  generate
    for (g = 0; g < NUM_TERM; g++)
    begin : g_term
      logic [REACT_W-1:0] cnt_r;
      logic               filt_r;
      logic               latch_r;
      logic               cval;
      logic               lvl;
      logic [2:0]         mode;
      logic [1:0]         ev;

      assign mode = link_cfg_r[g*LINK_FW +: 3];
      assign ev   = eval_cfg_r[g*EVAL_FW +: EVAL_FW];
      assign filt[g] = filt_r;
      assign latch[g] = latch_r;

      // any return to the old level restarts the wait
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          filt_r <= 1'b0;
          cnt_r  <= '0;
        end
        else if (sync2_r[g] == filt_r)
          cnt_r <= '0; // RULE_17
        // the first tick may fall at once, so one extra tick is waited
        else if (react_r == '0 || (tick && cnt_r >= react_r))
        begin
          filt_r <= sync2_r[g]; // RULE_08
          cnt_r  <= '0;
        end
        else if (tick)
          cnt_r <= cnt_r + REACT_W'(1);
      end

      // partner of a pair is the neighbouring terminal
      assign cval = link_val(mode, filt_r,
                             filt[g ^ 1]); // RULE_03 RULE_04 RULE_05
      assign lvl  = (ev == EVAL_LOW) ? ~cval : cval; // RULE_06
      assign latch_set[g] = ((ev == EVAL_RISE) && cval && !comb_r[g]) ||
                            ((ev == EVAL_FALL) && !cval && comb_r[g]);

      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
        begin
          comb_r[g] <= 1'b0;
          latch_r   <= 1'b0;
        end
        else
        begin
          comb_r[g] <= cval;
          if (latch_set[g])
            latch_r <= 1'b1; // RULE_18
          else if (func[F_CLEAR])
            latch_r <= 1'b0; // RULE_14
        end
      end

      assign term_act[g] = ev[1] ? latch_r : lvl;
    end

    for (g = 0; g < NUM_FUNC; g++)
    begin : g_func
      assign func[g] = |(func_map_r[g*MAP_FW +: NUM_TERM] &
                         term_act); // RULE_01 RULE_02
    end
  endgenerate

  // ----------------------------------------------------------------
  // functions out
  // ----------------------------------------------------------------
  logic [1:0] pset_nxt;
  logic       conflict_r;
  logic       both_run;

  assign pset_nxt = pset_code(func[F_PSET0], func[F_PSET1]);
  assign both_run = func[F_FWD] & func[F_REV];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      drive      <= '{default: 1'b0, param_set: PSET_4};
      conflict_r <= 1'b0;
    end
    else
    begin
      drive.forward_run_request <= func[F_FWD];
      drive.reverse_run_request <= func[F_REV] & ~func[F_FWD]; // RULE_16
      drive.hold_min_freq       <= func[F_HOLD];
      drive.fixed_freq          <= func[F_FIXED];
      drive.latch_clear         <= func[F_CLEAR];
      drive.param_set           <= pset_nxt; // RULE_15
      conflict_r                <= both_run;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [15:0] src_vec;
  assign src_vec = {status_src, 1'b0}; // RULE_09 RULE_13

  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_out
      logic [OUT_SEL_W-1:0] sel;
      logic                 inverted_input_option;
      logic                 bit_sel;
      assign sel = out_cfg_r[g*OUT_FW +: OUT_SEL_W];
      assign inverted_input_option = out_cfg_r[g*OUT_FW + OUT_INV_B];
      // a frequency selection on the second output yields an idle source
      assign bit_sel = (g != 0 && sel == SRC_FREQ) ? 1'b0 :
                       src_vec[sel]; // RULE_10
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
          oc_drive[g] <= 1'b0;
        else
          oc_drive[g] <= bit_sel ^ inverted_input_option; // RULE_12
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      relay_drive <= 1'b0;
    else
      relay_drive <= g_out[1].bit_sel ^ g_out[1].inverted_input_option; // RULE_11
  end

  // ----------------------------------------------------------------
  // interrupts and read side
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_ev  = {both_run & ~conflict_r, pset_nxt != drive.param_set,
                    latch_set};
  assign irq_clr = (wr_fire && aw_addr_r == IRQ_STAT_OFF) ?
                   wmask[IRQ_W-1:0] : '0;
  assign irq     = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      irq_stat_r <= '0;
    else
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev; // set beats clear
  end

  always_comb
  begin
    rhit_nxt  = 1'b1;
    rdata_nxt = '0;
    case (s_axi_araddr)
      LINK_CFG_OFF: rdata_nxt = link_cfg_r;
      EVAL_CFG_OFF: rdata_nxt = eval_cfg_r;
      FUNC_MAP_OFF: rdata_nxt = func_map_r;
      REACT_OFF:    rdata_nxt = {16'h0000, react_r};
      OUT_CFG_OFF:  rdata_nxt = out_cfg_r;
      STATUS_OFF:   rdata_nxt = {10'h000, drive.param_set, 1'b0, func,
                                 term_act, latch, filt};
      IRQ_STAT_OFF: rdata_nxt = {26'h0, irq_stat_r};
      IRQ_MASK_OFF: rdata_nxt = {26'h0, irq_mask_r};
      default:      rhit_nxt  = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rhit_nxt ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  fwd_precedence_a: assert property (both_run |=> // RULE_16
    drive.forward_run_request && !drive.reverse_run_request)
    else $error("reverse run not suppressed by forward run");
  pset_select_a: assert property ( // RULE_15
    func[F_PSET0] && !func[F_PSET1] |=> drive.param_set == PSET_3)
    else $error("bit 0 alone did not select set 3");
  filter_wait_a: assert property ( // RULE_17
    $changed(filt[0]) |-> $past(g_term[0].cnt_r) >= react_r)
    else $error("input accepted before reaction time");
  latch_hold_a: assert property ( // RULE_18
    latch_set[0] |=> latch[0] ##1 (latch[0] || $past(func[F_CLEAR])))
    else $error("edge latch lost without clear");
  latch_clear_a: assert property ( // RULE_14
    func[F_CLEAR] && latch_set == '0 |=> latch == '0)
    else $error("latch clear left a latch set");
  freq_block_a: assert property ( // RULE_10
    g_out[1].sel == SRC_FREQ |=> oc_drive[1] == $past(g_out[1].inverted_input_option))
    else $error("frequency reached second output");
  relay_follow_a: assert property ( // RULE_11
    $changed(oc_drive[1]) |-> $changed(relay_drive))
    else $error("relay out of step with second output");
  out_polarity_a: assert property ( // RULE_12
    oc_drive[0] == ($past(g_out[0].bit_sel) ^ $past(g_out[0].inverted_input_option)))
    else $error("output polarity wrong");
  multi_func_a: assert property ( // RULE_02
    term_act[3] && func_map_r[F_FWD*MAP_FW+3] && func_map_r[F_HOLD*MAP_FW+3]
    |=> drive.forward_run_request && drive.hold_min_freq)
    else $error("shared terminal did not drive both functions");

  both_run_c:  cover property (both_run ##1 !both_run);
  latch_set_c: cover property (latch_set[0] ##[1:20] func[F_CLEAR]);
  pset_chg_c:  cover property ($changed(drive.param_set));
  irq_c:       cover property (irq ##1 !irq);

endmodule
`default_nettype wire

// ---- hw/ctl_term_pkg.sv ----
package ctl_term_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_TERM  = 4;
  localparam int NUM_FUNC  = 7;
  localparam int NUM_OUT   = 2;
  localparam int ADDR_W    = 8;
  localparam int REACT_W   = 16;
  localparam int IRQ_W     = 6;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] LINK_CFG_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] EVAL_CFG_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] FUNC_MAP_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] REACT_OFF    = 8'h0C;
  localparam logic [ADDR_W-1:0] OUT_CFG_OFF  = 8'h10;
  localparam logic [ADDR_W-1:0] STATUS_OFF   = 8'h14;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFF = 8'h18;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 8'h1C;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int LINK_FW   = 4;
  localparam int EVAL_FW   = 2;
  localparam int MAP_FW    = 4;
  localparam int OUT_FW    = 8;
  localparam int OUT_SEL_W = 4;
  localparam int OUT_INV_B = 4;

  // terminal 0 hold-min, 1 set bit 0, 2 reverse, 3 forward
  localparam logic [31:0] FUNC_MAP_RST = 32'h0001_0248;
  localparam logic [31:0] LINK_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] EVAL_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] OUT_CFG_RST  = 32'h0000_0000;
  localparam logic [REACT_W-1:0] REACT_RST = 16'h000A;

  // function index inside the map register
  localparam int F_FWD   = 0;
  localparam int F_REV   = 1;
  localparam int F_PSET0 = 2;
  localparam int F_PSET1 = 3;
  localparam int F_HOLD  = 4;
  localparam int F_FIXED = 5;
  localparam int F_CLEAR = 6;

  // irq bit positions above the per-terminal latch bits
  localparam int IRQ_PSET = 4;
  localparam int IRQ_CONF = 5;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] LINK_DIRECT  = 3'h0;
  localparam logic [2:0] LINK_INV     = 3'h1;
  localparam logic [2:0] LINK_OR      = 3'h2;
  localparam logic [2:0] LINK_OR_INV  = 3'h3;
  localparam logic [2:0] LINK_AND     = 3'h4;
  localparam logic [2:0] LINK_AND_INV = 3'h5;

  localparam logic [1:0] EVAL_HIGH = 2'h0;
  localparam logic [1:0] EVAL_LOW  = 2'h1;
  localparam logic [1:0] EVAL_RISE = 2'h2;
  localparam logic [1:0] EVAL_FALL = 2'h3;

  localparam logic [1:0] PSET_1 = 2'h0;
  localparam logic [1:0] PSET_2 = 2'h1;
  localparam logic [1:0] PSET_3 = 2'h2;
  localparam logic [1:0] PSET_4 = 2'h3;

  localparam logic [3:0] SRC_FREQ = 4'hE;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS    = 25;
  localparam int TICK_NS   = 1000;
  localparam int TICK_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W    = 6;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic temp_warn;
    logic freq_pulse;
    logic overload_integral_fault;
    logic ready;
    logic dc_braking;
    logic zero_speed;
    logic general_fault;
    logic overtemp2;
    logic overtemp1;
    logic short_circuit;
    logic overvolt2;
    logic overvolt1;
    logic undervolt;
    logic motor_ptc;
    logic multi_function;
  } status_src_type;

  typedef struct packed {
    logic       forward_run_request;
    logic       reverse_run_request;
    logic       hold_min_freq;
    logic       fixed_freq;
    logic       latch_clear;
    logic [1:0] param_set;
  } drive_func_type;

endpackage
